// file: shared/cmc_pkg.sv
// constants, codes and carriers shared by the clock multiplier control logic
// assumes a byte-wide special-function register port and a 250 MHz ref_clk
package cmc_pkg;

  // register map and field layout
  localparam logic [7:0] CMC_CTRL_ADDR  = 8'hbe;
  localparam logic [7:0] CMC_CTRL_RESET = 8'h00;
  localparam int         CMC_ENABLE_BIT = 7;
  localparam int         CMC_INIT_BIT   = 6;
  localparam int         CMC_READY_BIT  = 5;
  localparam int         CMC_SEL_LSB    = 0;
  localparam int         CMC_SEL_W      = 2;

  // multiplication factor of the analog core
  localparam logic [2:0] CMC_FACTOR     = 3'h4;

  // enable-to-initialize settle time
  localparam int CMC_CLK_PERIOD_NS   = 4;
  localparam int CMC_ENABLE_WAIT_NS  = 5000;
  localparam int CMC_ENABLE_WAIT_CYC =
    (CMC_ENABLE_WAIT_NS + CMC_CLK_PERIOD_NS - 1) / CMC_CLK_PERIOD_NS;
  localparam int CMC_WAIT_W          = $clog2(CMC_ENABLE_WAIT_CYC + 1);

  // input select codes
  typedef enum logic [1:0] {
    CMC_SEL_INT_HALF = 2'b00,
    CMC_SEL_EXT      = 2'b01,
    CMC_SEL_EXT_HALF = 2'b10,
    CMC_SEL_RESERVED = 2'b11
  } cmc_sel_t;

  // control state of the multiplier
  typedef enum logic [1:0] {
    CMC_ST_OFF     = 2'b00,
    CMC_ST_ENABLED = 2'b01,
    CMC_ST_LOCKING = 2'b10,
    CMC_ST_READY   = 2'b11
  } cmc_state_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } cmc_sfr_req_t;

  // controls to the analog multiplier core
  typedef struct packed {
    logic       enable;
    logic       init;
    logic       src_ext;
    logic       pre_div2;
    logic [2:0] factor;
  } cmc_analog_ctrl_t;

endpackage

// file: hw/cmc_pin_sync.sv
// three-flop synchroniser with agreement filter for one asynchronous pin
// assumes ref_clk domain, asynchronous active-high reset, clock enable ce
`timescale 1ns/1ns
module cmc_pin_sync
(
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic pin,
  output logic      level
);

  logic stage1;
  logic stage2;
  logic stage3;

  // shift chain; level follows only once stages two and three agree
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level  <= 1'b0;
    end
    else if (ce)
    begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        level <= stage3;
    end
  end

endmodule

// file: hw/cmc_clock_multiplier_control.sv
// control and status register logic for the on-chip clock multiplier
// assumes a byte special-function register port on ref_clk, analog lock and
// external oscillator stable indications arriving asynchronously on pins
`timescale 1ns/1ns

module cmc_clock_multiplier_control
(
  input  wire logic                      ref_clk,
  input  wire logic                      reset,
  input  wire logic                      ce,
  input  wire cmc_pkg::cmc_sfr_req_t     sfr_req,
  output logic [7:0]                     sfr_rdata,
  input  wire logic                      mul_lock_pin,
  input  wire logic                      ext_osc_stable_pin,
  output cmc_pkg::cmc_analog_ctrl_t      analog_ctrl,
  output logic                           multiplier_ready,
  output logic                           mul_settled,
  output logic                           init_too_early,
  output logic                           init_ext_unstable
);

  // register fields and control state
  logic                           multiplier_enable;
  logic                           multiplier_initialize;
  cmc_pkg::cmc_sel_t              multiplier_input_select;
  cmc_pkg::cmc_state_t            state;
  cmc_pkg::cmc_state_t            next_state;
  logic [cmc_pkg::CMC_WAIT_W-1:0] wait_cnt;

  // synchronised pin levels
  logic lock_level;
  logic ext_stable_level;

  cmc_pin_sync u_lock_sync
  (
    .ref_clk (ref_clk),
    .reset   (reset),
    .ce      (ce),
    .pin     (mul_lock_pin),
    .level   (lock_level)
  );

  cmc_pin_sync u_ext_sync
  (
    .ref_clk (ref_clk),
    .reset   (reset),
    .ce      (ce),
    .pin     (ext_osc_stable_pin),
    .level   (ext_stable_level)
  );

  // register port decode
  wire       ctrl_hit = (sfr_req.addr == cmc_pkg::CMC_CTRL_ADDR);
  wire       ctrl_wr  = ce & sfr_req.wr & ctrl_hit;
  wire       ctrl_rd  = ce & sfr_req.rd & ctrl_hit;
  wire       wr_en    = sfr_req.wdata[cmc_pkg::CMC_ENABLE_BIT];
  wire       wr_init  = sfr_req.wdata[cmc_pkg::CMC_INIT_BIT];
  wire [1:0] wr_sel   =
    sfr_req.wdata[cmc_pkg::CMC_SEL_LSB +: cmc_pkg::CMC_SEL_W];

  // write effects on the multiplier
  wire sel_reserved  = (multiplier_input_select == cmc_pkg::CMC_SEL_RESERVED);
  wire wsel_reserved = (wr_sel == cmc_pkg::CMC_SEL_RESERVED);
  wire enable_drop   = ctrl_wr & ~wr_en;
  wire sel_change    = ctrl_wr & (wr_sel != multiplier_input_select);
  // initialize only counts when already enabled before this write
  wire init_start    = ctrl_wr & multiplier_enable & wr_en & wr_init
                     & ~wsel_reserved;
  wire settled_now   = (wait_cnt == cmc_pkg::CMC_WAIT_W'(cmc_pkg::CMC_ENABLE_WAIT_CYC));
  // select as it stands once this cycle's write has landed, so the core
  // routing never lags the register by a cycle
  wire [1:0] next_sel  = ctrl_wr ? wr_sel : multiplier_input_select;
  wire       next_rsvd = (next_sel == cmc_pkg::CMC_SEL_RESERVED);
  wire src_ext_now   = (next_sel != cmc_pkg::CMC_SEL_INT_HALF);

  // readback image; bits 4 to 2 read zero
  wire [7:0] ctrl_image = {multiplier_enable,
                           multiplier_initialize,
                           multiplier_ready,
                           3'h0,
                           multiplier_input_select};

  // next control state
  always_comb
  begin
    next_state = state;
    unique case (state)
      cmc_pkg::CMC_ST_OFF:
      begin
        if (ctrl_wr & wr_en)
          next_state = cmc_pkg::CMC_ST_ENABLED;
      end
      cmc_pkg::CMC_ST_ENABLED:
      begin
        if (enable_drop)
          next_state = cmc_pkg::CMC_ST_OFF;
        else if (init_start)
          next_state = cmc_pkg::CMC_ST_LOCKING;
      end
      cmc_pkg::CMC_ST_LOCKING:
      begin
        if (enable_drop)
          next_state = cmc_pkg::CMC_ST_OFF;
        else if (sel_change)
          next_state = cmc_pkg::CMC_ST_ENABLED;
        else if (lock_level & ~sel_reserved)
          next_state = cmc_pkg::CMC_ST_READY;
      end
      cmc_pkg::CMC_ST_READY:
      begin
        if (enable_drop)
          next_state = cmc_pkg::CMC_ST_OFF;
        else if (sel_change)
          next_state = cmc_pkg::CMC_ST_ENABLED;
        else if (init_start | ~lock_level)
          next_state = cmc_pkg::CMC_ST_LOCKING;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      state <= cmc_pkg::CMC_ST_OFF;
    else if (ce)
      state <= next_state;
  end

  // writable fields; ready and bits 4 to 2 are not writable
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      multiplier_enable       <= cmc_pkg::CMC_CTRL_RESET[cmc_pkg::CMC_ENABLE_BIT];
      multiplier_initialize   <= cmc_pkg::CMC_CTRL_RESET[cmc_pkg::CMC_INIT_BIT];
      multiplier_input_select <= cmc_pkg::cmc_sel_t'(
        cmc_pkg::CMC_CTRL_RESET[cmc_pkg::CMC_SEL_LSB +: cmc_pkg::CMC_SEL_W]);
    end
    else if (ctrl_wr)
    begin
      multiplier_enable       <= wr_en;
      multiplier_initialize   <= wr_init & wr_en & multiplier_enable & ~wsel_reserved;
      multiplier_input_select <= cmc_pkg::cmc_sel_t'(wr_sel);
    end
  end

  // enable settle timer, restarts on every fresh enable
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      wait_cnt <= '0;
    else if (ce)
    begin
      if (next_state == cmc_pkg::CMC_ST_OFF)
        wait_cnt <= '0;
      else if (~settled_now)
        wait_cnt <= wait_cnt + 1'b1;
    end
  end

  // status flags
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      multiplier_ready  <= 1'b0;
      mul_settled       <= 1'b0;
      init_too_early    <= 1'b0;
      init_ext_unstable <= 1'b0;
    end
    else if (ce)
    begin
      multiplier_ready <= (next_state == cmc_pkg::CMC_ST_READY);
      mul_settled      <= settled_now & (next_state != cmc_pkg::CMC_ST_OFF);
      // set wins over clear in the same cycle
      if (init_start & ~mul_settled) // wait must be strictly over
        init_too_early <= 1'b1;
      else if (enable_drop)
        init_too_early <= 1'b0;
      if (init_start & src_ext_now & ~ext_stable_level)
        init_ext_unstable <= 1'b1;
      else if (enable_drop)
        init_ext_unstable <= 1'b0;
    end
  end

  // analog core controls
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      analog_ctrl <= '0;
    else if (ce)
    begin
      analog_ctrl.enable   <= (next_state != cmc_pkg::CMC_ST_OFF) & ~next_rsvd;
      analog_ctrl.init     <= (next_state == cmc_pkg::CMC_ST_LOCKING)
                            | (next_state == cmc_pkg::CMC_ST_READY);
      analog_ctrl.src_ext  <= src_ext_now;
      analog_ctrl.pre_div2 <= (next_sel != cmc_pkg::CMC_SEL_EXT);
      analog_ctrl.factor   <= cmc_pkg::CMC_FACTOR;
    end
  end

  // registered read data, zero when not addressed
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      sfr_rdata <= 8'h00;
    else if (ce)
      sfr_rdata <= ctrl_rd ? ctrl_image : 8'h00;
  end

endmodule

// file: tb/cmc_ctrl_props.sv
// assertions on the clock multiplier control ports
// assumes binding onto cmc_clock_multiplier_control, one ref_clk domain
`timescale 1ns/1ns
module cmc_ctrl_props
(
  input wire logic                      ref_clk,
  input wire logic                      reset,
  input wire logic                      ce,
  input wire cmc_pkg::cmc_sfr_req_t     sfr_req,
  input wire logic [7:0]                sfr_rdata,
  input wire logic                      mul_lock_pin,
  input wire logic                      ext_osc_stable_pin,
  input wire cmc_pkg::cmc_analog_ctrl_t analog_ctrl,
  input wire logic                      multiplier_ready,
  input wire logic                      mul_settled,
  input wire logic                      init_too_early,
  input wire logic                      init_ext_unstable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // decoded control register accesses
  logic wr_hit;
  logic rd_hit;
  assign wr_hit = ce && sfr_req.wr && sfr_req.addr == cmc_pkg::CMC_CTRL_ADDR;
  assign rd_hit = ce && sfr_req.rd && sfr_req.addr == cmc_pkg::CMC_CTRL_ADDR;
  // enable bit as last written to the control register
  logic en_shadow;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      en_shadow <= 1'b0;
    else if (wr_hit)
      en_shadow <= sfr_req.wdata[7];
  end
  // settled core initialising with lock held and no writes
  sequence s_lock_held;
    (ce && !sfr_req.wr && mul_settled && analog_ctrl.init && mul_lock_pin
     && !init_ext_unstable)[*8];
  endsequence
  sequence s_read_steady;
    rd_hit ##1 $stable(multiplier_ready);
  endsequence
  property p_rsvd_zero;
    sfr_rdata[4:2] == 3'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("unused bits read nonzero");
  property p_ready_read;
    s_read_steady |-> sfr_rdata[5] == multiplier_ready;
  endproperty
  a_ready_read: assert property (p_ready_read) else $error("ready bit differs");
  property p_off;
    wr_hit && !sfr_req.wdata[7] |=> !analog_ctrl.enable && !analog_ctrl.init
      && !multiplier_ready && !mul_settled && !init_too_early && !init_ext_unstable;
  endproperty
  a_off: assert property (p_off) else $error("disable left state behind");
  property p_enable;
    wr_hit && sfr_req.wdata[7] |=> analog_ctrl.enable == ($past(sfr_req.wdata[1:0]) != 2'h3);
  endproperty
  a_enable: assert property (p_enable) else $error("enable wrong after write");
  property p_select;
    wr_hit && sfr_req.wdata[1:0] != 2'h3 |=> analog_ctrl.src_ext ==
      ($past(sfr_req.wdata[1:0]) != 2'h0) && analog_ctrl.pre_div2 ==
      ($past(sfr_req.wdata[1:0]) != 2'h1);
  endproperty
  a_select: assert property (p_select) else $error("source routing wrong");
  property p_factor;
    !reset && ce |=> analog_ctrl.factor == cmc_pkg::CMC_FACTOR;
  endproperty
  a_factor: assert property (p_factor) else $error("factor not four");
  property p_init_refused;
    wr_hit && sfr_req.wdata[6] && !en_shadow |=> !analog_ctrl.init;
  endproperty
  a_init_refused: assert property (p_init_refused) else $error("init while disabled");
  property p_lock;
    s_lock_held |-> multiplier_ready && analog_ctrl.enable;
  endproperty
  a_lock: assert property (p_lock) else $error("ready missing after lock");
endmodule

bind cmc_clock_multiplier_control cmc_ctrl_props u_props
(
  .ref_clk(ref_clk), .reset(reset), .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .mul_lock_pin(mul_lock_pin), .ext_osc_stable_pin(ext_osc_stable_pin),
  .analog_ctrl(analog_ctrl), .multiplier_ready(multiplier_ready),
  .mul_settled(mul_settled), .init_too_early(init_too_early),
  .init_ext_unstable(init_ext_unstable)
);

// file: tb/testbench.sv
// self-checking bench for the clock multiplier control register
// assumes the design answers reads one cycle after the read edge
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("BAD %s expected %h seen %h", nm, ex, got); \
    end \
  end
module testbench;
  logic                      ref_clk = 1'b0;
  logic                      reset = 1'b1;
  logic                      ce = 1'b1;
  cmc_pkg::cmc_sfr_req_t     sfr_req = '0;
  logic                      lock = 1'b0;
  logic                      ext = 1'b0;
  logic [7:0]                sfr_rdata;
  cmc_pkg::cmc_analog_ctrl_t analog_ctrl;
  logic                      ready;
  logic                      settled;
  logic                      early;
  logic                      unstable;
  int                        n_mismatch = 0;
  int                        samples_checked = 0;
  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;
  cmc_clock_multiplier_control dut
  (
    .ref_clk(ref_clk), .reset(reset), .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .mul_lock_pin(lock), .ext_osc_stable_pin(ext), .analog_ctrl(analog_ctrl),
    .multiplier_ready(ready), .mul_settled(settled), .init_too_early(early),
    .init_ext_unstable(unstable)
  );
  task test_done;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_req <= '{a, 1'b1, 1'b0, d};
    @(posedge ref_clk);
    sfr_req.wr <= 1'b0;
    #1;
  endtask
  // one-cycle read strobe, data checked after the taking edge
  task rd(input logic [7:0] a, input logic [7:0] ex);
    @(posedge ref_clk);
    sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge ref_clk);
    sfr_req.rd <= 1'b0;
    #1;
    `CHK("rdata", ex, sfr_rdata)
  endtask
  // bounded wait on settled (0) or ready (1)
  task automatic wait_lvl(input int i, input logic lvl);
    int k = 0;
    while ((i == 0 ? settled : ready) !== lvl && k < 3000)
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k == 3000)
    begin
      n_mismatch++;
      test_done();
    end
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    rd(8'hbe, 8'h00);
    wr(8'hbe, 8'h5d);
    rd(8'hbe, 8'h01);
    for (int s = 0; s < 3; s++)
    begin
      wr(8'hbe, {6'h20, s[1:0]});
      `CHK("src_ext", s != 0, analog_ctrl.src_ext)
      `CHK("pre_div2", s != 1, analog_ctrl.pre_div2)
    end
    wr(8'hbe, 8'h83);
    `CHK("enable", 1'b0, analog_ctrl.enable)
    wr(8'hbe, 8'h00);
    wr(8'hbe, 8'h81);
    wr(8'hbe, 8'hc1);
    wait_lvl(0, 1'b1);
    `CHK("too_early", 1'b1, early)
    `CHK("ext_unstable", 1'b1, unstable)
    wr(8'hbe, 8'h00);
    `CHK("flags", 2'h0, {early, unstable})
    @(posedge ref_clk);
    ext <= 1'b1;
    wr(8'hbe, 8'h01);
    wr(8'hbe, 8'h81);
    `CHK("enable", 1'b1, analog_ctrl.enable)
    wait_lvl(0, 1'b1);
    wr(8'hbe, 8'hc1);
    @(posedge ref_clk);
    lock <= 1'b1;
    wait_lvl(1, 1'b1);
    rd(8'hbe, 8'he1);
    `CHK("factor", 3'h4, analog_ctrl.factor)
    `CHK("flags", 2'h0, {early, unstable})
    // lock loss drops ready but keeps the core initialising
    @(posedge ref_clk);
    lock <= 1'b0;
    wait_lvl(1, 1'b0);
    `CHK("init", 1'b1, analog_ctrl.init)
    @(posedge ref_clk);
    lock <= 1'b1;
    wait_lvl(1, 1'b1);
    wr(8'hbe, 8'h00);
    `CHK("ready", 1'b0, ready)
    rd(8'hbe, 8'h00);
    rd(8'hbf, 8'h00);
    // a write with the clock enable low must leave everything frozen
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(8'hbe, 8'h81);
    `CHK("frozen", 1'b0, analog_ctrl.enable)
    @(posedge ref_clk);
    ce <= 1'b1;
    rd(8'hbe, 8'h00);
    test_done();
  end
endmodule
